// >>> rtl/pcm_pkg.sv
// Constants for the parameter channel message control block
package pcm_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [6:0] EVENT_LOW_OFF = 7'h05;
  localparam logic [6:0] LONG_BUF_OFF = 7'h20;
  localparam logic [6:0] LONG_ADDR_H_OFF = 7'h28;
  localparam logic [6:0] LONG_ADDR_L_OFF = 7'h29;
  localparam logic [6:0] LONG_OFF_H_OFF = 7'h2A;
  localparam logic [6:0] LONG_OFF_L_OFF = 7'h2B;
  localparam logic [6:0] LONG_CTRL_OFF = 7'h2C;
  localparam logic [6:0] MIRROR_ANS_OFF = 7'h2F;
  localparam logic [6:0] REMOTE_ANS_OFF = 7'h37;
  localparam logic [6:0] EVENT_SHORT_OFF = 7'h3F;
  localparam logic [6:0] REMOTE_LO_OFF = 7'h40;
  localparam logic [6:0] MIRROR_LO_OFF = 7'h60;
  localparam logic [6:0] MIRROR_HI_OFF = 7'h67;
  localparam logic [6:0] SEC_POS_HI_IDX = 7'h04;
  // Field positions
  localparam int LONG_FREE_BIT = 0;
  localparam int SHORT_FREE_BIT = 0;
  localparam int LONG_START_BIT = 0;
  localparam int LONG_DIR_BIT = 6;
  localparam int LONG_ERR_BIT = 5;
  localparam int ONLINE_SHORT_FREE_BIT = 0;
  // Sizes and reset values
  localparam int LONG_BUF_BYTES = 8;
  localparam int SEC_POS_BYTES = 5;
  localparam int MIRROR_REGS = 8;
  localparam logic [7:0] EVENT_LOW_RST = 8'h01;
  localparam logic [7:0] EVENT_SHORT_RST = 8'h01;
  localparam logic [7:0] REG_RST = 8'h00;
endpackage : pcm_pkg

// >>> rtl/pcm_buf_mem.sv
// Long message data buffer with host byte port and link fill port
`timescale 1ns/1ps
module pcm_buf_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8,
  parameter int IDX_W = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Host byte write
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // Whole-buffer fill from the link
  input wire logic fill_en,
  input wire logic [DEPTH*WIDTH-1:0] fill_data,
  // Registered byte read and full contents
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data,
  output logic [DEPTH*WIDTH-1:0] flat
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [WIDTH-1:0] rd_ff;

  // Link fill wins: returned data must not be torn by a late host write
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      nxt_mem[i] = mem_ff[i];
      if (fill_en)
        nxt_mem[i] = fill_data[i*WIDTH +: WIDTH];
      else if (wr_en && (wr_idx == IDX_W'(i)))
        nxt_mem[i] = wr_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_ff[i] <= '0;
      rd_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_ff[i] <= nxt_mem[i];
      rd_ff <= mem_ff[rd_idx];
    end
  end

  assign rd_data = rd_ff;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_flat
      assign flat[g*WIDTH +: WIDTH] = mem_ff[g];
    end
  endgenerate
endmodule : pcm_buf_mem

// >>> rtl/pcm_ctrl.sv
// Parameter channel short/long message control and secondary position store
//
// Summary of operation
// R01: Capture secondary position on its every-eighth frame
// R02: Five secondary position bytes, second interface only
// R03: External logic cross checks both safe positions
// R04: External check uses only specified upper bits
// R05: Remote registers mirrored at local 40h-7Fh
// R06: Remote access first interface only, except 60h-67h
// R07: Remote answer to 37h, mirror answer 2Fh
// R08: Host waits for cable-delayed remote answer
// R09: Short free flag low busy, set on answer
// R10: Short free flag is online status bit 0
// R11: Mirror read answer available immediately
// R12: Only one short message outstanding
// R13: Short and long messages run concurrently
// R14: Host loads buffer, address, offset, control registers
// R15: Returned long data written into eight buffers
// R16: Long free flag cleared running, set finished
// R17: Host may clear long free flag directly
// R18: Host reads long data after flag set
`timescale 1ns/1ps
module pcm_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // First safety host interface
  input wire logic [6:0] s1_addr,
  input wire logic s1_wr,
  input wire logic s1_rd,
  input wire logic [7:0] s1_wdata,
  output logic [7:0] s1_rdata,
  output logic s1_rvalid,
  output logic [7:0] s1_online_status,
  // Second safety host interface
  input wire logic [6:0] s2_addr,
  input wire logic s2_rd,
  output logic [7:0] s2_rdata,
  output logic s2_rvalid,
  // Secondary safe position from the frame decoder
  input wire logic link_pos2_valid,
  input wire logic [39:0] link_pos2,
  // Short message link side
  output logic sm_req,
  output logic sm_write,
  output logic [6:0] sm_addr,
  output logic [7:0] sm_wdata,
  input wire logic sm_ans_valid,
  input wire logic [7:0] sm_ans_data,
  // Long message link side
  output logic lm_req,
  output logic [7:0] lm_addr_h,
  output logic [7:0] lm_addr_l,
  output logic [7:0] lm_off_h,
  output logic [7:0] lm_off_l,
  output logic [63:0] lm_data,
  input wire logic lm_done,
  input wire logic lm_err,
  input wire logic [63:0] lm_rd_data
);
  logic [7:0] ev_low_ff, nxt_ev_low, ev_short_ff, nxt_ev_short;
  logic [7:0] mir_ans_ff, nxt_mir_ans, rem_ans_ff, nxt_rem_ans;
  logic [7:0] addr_h_ff, nxt_addr_h, addr_l_ff, nxt_addr_l;
  logic [7:0] off_h_ff, nxt_off_h, off_l_ff, nxt_off_l;
  logic [7:0] mirror_ff [pcm_pkg::MIRROR_REGS];
  logic [7:0] nxt_mirror [pcm_pkg::MIRROR_REGS];
  logic [39:0] pos2_ff, nxt_pos2;
  logic sm_busy_ff, nxt_sm_busy, lm_busy_ff, nxt_lm_busy;
  logic sm_req_ff, nxt_sm_req, sm_write_ff, nxt_sm_write;
  logic [6:0] sm_addr_ff, nxt_sm_addr;
  logic [7:0] sm_wdata_ff, nxt_sm_wdata;
  logic lm_req_ff, nxt_lm_req;
  logic [63:0] lm_data_ff, nxt_lm_data;
  logic rd1_ff, nxt_rd1;
  logic [6:0] rd1_addr_ff, nxt_rd1_addr;
  logic [7:0] s1_rdata_ff, nxt_s1_rdata, s2_rdata_ff, nxt_s2_rdata, online_ff, nxt_online;
  logic s1_rvalid_ff, nxt_s1_rvalid, s2_rvalid_ff, nxt_s2_rvalid;
  logic buf_we, buf_fill;
  logic [7:0] buf_rd;
  logic [63:0] buf_flat;
  logic s1_remote, s1_mirror, s2_mirror, s1_true_remote, sm_take, lm_start;

  assign s1_remote = s1_addr >= pcm_pkg::REMOTE_LO_OFF;
  assign s1_mirror = (s1_addr >= pcm_pkg::MIRROR_LO_OFF) && (s1_addr <= pcm_pkg::MIRROR_HI_OFF);
  assign s2_mirror = (s2_addr >= pcm_pkg::MIRROR_LO_OFF) && (s2_addr <= pcm_pkg::MIRROR_HI_OFF);
  assign s1_true_remote = s1_remote && !s1_mirror && (s1_rd || s1_wr);
  // A request while the previous answer is still out is dropped
  assign sm_take = s1_true_remote && !sm_busy_ff; // see R12
  assign lm_start = s1_wr && (s1_addr == pcm_pkg::LONG_CTRL_OFF)
    && s1_wdata[pcm_pkg::LONG_START_BIT] && !lm_busy_ff;
  assign buf_we = s1_wr && (s1_addr[6:3] == pcm_pkg::LONG_BUF_OFF[6:3]);
  assign buf_fill = lm_done && lm_busy_ff && addr_h_ff[pcm_pkg::LONG_DIR_BIT]; // see R15

  pcm_buf_mem #(
    .DEPTH(pcm_pkg::LONG_BUF_BYTES),
    .WIDTH(8),
    .IDX_W(3)
  ) u_buf (
    .mclk(mclk),
    .srst(srst),
    .wr_en(buf_we),
    .wr_idx(s1_addr[2:0]),
    .wr_data(s1_wdata),
    .fill_en(buf_fill),
    .fill_data(lm_rd_data),
    .rd_idx(s1_addr[2:0]),
    .rd_data(buf_rd),
    .flat(buf_flat)
  );

  always_comb
  begin
    nxt_ev_low = ev_low_ff;
    nxt_ev_short = ev_short_ff;
    nxt_mir_ans = mir_ans_ff;
    nxt_rem_ans = rem_ans_ff;
    nxt_addr_h = addr_h_ff;
    nxt_addr_l = addr_l_ff;
    nxt_off_h = off_h_ff;
    nxt_off_l = off_l_ff;
    nxt_mirror = mirror_ff;
    nxt_pos2 = pos2_ff;
    nxt_sm_busy = sm_busy_ff;
    nxt_lm_busy = lm_busy_ff;
    nxt_sm_req = 1'b0;
    nxt_sm_write = sm_write_ff;
    nxt_sm_addr = sm_addr_ff;
    nxt_sm_wdata = sm_wdata_ff;
    nxt_lm_req = 1'b0;
    nxt_lm_data = lm_data_ff;
    if (link_pos2_valid)
      nxt_pos2 = link_pos2; // see R01
    // Long message registers; host writes are ignored while a long message runs
    if (s1_wr && !lm_busy_ff)
    begin
      case (s1_addr)
        pcm_pkg::LONG_ADDR_H_OFF: nxt_addr_h = s1_wdata;
        pcm_pkg::LONG_ADDR_L_OFF: nxt_addr_l = s1_wdata;
        pcm_pkg::LONG_OFF_H_OFF: nxt_off_h = s1_wdata;
        pcm_pkg::LONG_OFF_L_OFF: nxt_off_l = s1_wdata;
        default: ;
      endcase
    end
    // Host clear of the long free flag; a finishing message still sets it
    if (s1_wr && (s1_addr == pcm_pkg::EVENT_LOW_OFF) && s1_wdata[pcm_pkg::LONG_FREE_BIT])
      nxt_ev_low[pcm_pkg::LONG_FREE_BIT] = 1'b0; // see R17
    if (lm_start)
    begin
      nxt_lm_busy = 1'b1;
      nxt_lm_req = 1'b1;
      nxt_lm_data = buf_flat;
      nxt_ev_low[pcm_pkg::LONG_FREE_BIT] = 1'b0; // see R16
    end
    else if (lm_done && lm_busy_ff)
    begin
      nxt_lm_busy = 1'b0;
      nxt_addr_h[pcm_pkg::LONG_ERR_BIT] = lm_err;
      nxt_ev_low[pcm_pkg::LONG_FREE_BIT] = 1'b1; // see R16
    end
    // Short messages are independent of the long message state
    if (sm_take)
    begin
      nxt_sm_busy = 1'b1; // see R13
      nxt_sm_req = 1'b1;
      nxt_sm_write = s1_wr;
      nxt_sm_addr = s1_addr; // see R05
      nxt_sm_wdata = s1_wdata;
      nxt_ev_short[pcm_pkg::SHORT_FREE_BIT] = 1'b0; // see R09
    end
    else if (sm_ans_valid && sm_busy_ff)
    begin
      nxt_sm_busy = 1'b0;
      nxt_rem_ans = sm_ans_data; // see R07
      nxt_ev_short[pcm_pkg::SHORT_FREE_BIT] = 1'b1; // see R09
      if (sm_addr_ff < pcm_pkg::REMOTE_LO_OFF + 7'(pcm_pkg::MIRROR_REGS))
        nxt_mirror[sm_addr_ff[2:0]] = sm_ans_data;
    end
    // Mirror copies live here, so their answer needs no link round trip
    if (s1_rd && s1_mirror)
      nxt_mir_ans = mirror_ff[s1_addr[2:0]]; // see R11
    else if (s2_rd && s2_mirror)
      nxt_mir_ans = mirror_ff[s2_addr[2:0]]; // see R06
  end

  always_comb
  begin
    nxt_rd1 = s1_rd;
    nxt_rd1_addr = s1_rd ? s1_addr : rd1_addr_ff;
    nxt_s1_rvalid = rd1_ff;
    nxt_s2_rvalid = s2_rd;
    nxt_online = 8'h00;
    nxt_online[pcm_pkg::ONLINE_SHORT_FREE_BIT] = nxt_ev_short[pcm_pkg::SHORT_FREE_BIT]; // see R10
    nxt_s1_rdata = s1_rdata_ff;
    if (rd1_ff)
    begin
      nxt_s1_rdata = 8'h00;
      if (rd1_addr_ff[6:3] == pcm_pkg::LONG_BUF_OFF[6:3])
        nxt_s1_rdata = buf_rd; // see R18
      else if ((rd1_addr_ff >= pcm_pkg::MIRROR_LO_OFF) && (rd1_addr_ff <= pcm_pkg::MIRROR_HI_OFF))
        nxt_s1_rdata = mirror_ff[rd1_addr_ff[2:0]];
      else
      begin
        case (rd1_addr_ff)
          pcm_pkg::EVENT_LOW_OFF: nxt_s1_rdata = ev_low_ff;
          pcm_pkg::LONG_ADDR_H_OFF: nxt_s1_rdata = addr_h_ff;
          pcm_pkg::LONG_ADDR_L_OFF: nxt_s1_rdata = addr_l_ff;
          pcm_pkg::LONG_OFF_H_OFF: nxt_s1_rdata = off_h_ff;
          pcm_pkg::LONG_OFF_L_OFF: nxt_s1_rdata = off_l_ff;
          pcm_pkg::MIRROR_ANS_OFF: nxt_s1_rdata = mir_ans_ff;
          pcm_pkg::REMOTE_ANS_OFF: nxt_s1_rdata = rem_ans_ff;
          pcm_pkg::EVENT_SHORT_OFF: nxt_s1_rdata = ev_short_ff;
          default: nxt_s1_rdata = 8'h00;
        endcase
      end
    end
    // Second interface sees the position bytes and the mirrors only
    nxt_s2_rdata = s2_rdata_ff;
    if (s2_rd)
    begin
      nxt_s2_rdata = 8'h00;
      if (s2_addr <= pcm_pkg::SEC_POS_HI_IDX)
        nxt_s2_rdata = pos2_ff[s2_addr[2:0]*8 +: 8]; // see R02
      else if (s2_mirror)
        nxt_s2_rdata = mirror_ff[s2_addr[2:0]]; // see R06
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ev_low_ff <= pcm_pkg::EVENT_LOW_RST;
      ev_short_ff <= pcm_pkg::EVENT_SHORT_RST;
      mir_ans_ff <= pcm_pkg::REG_RST;
      rem_ans_ff <= pcm_pkg::REG_RST;
      addr_h_ff <= pcm_pkg::REG_RST;
      addr_l_ff <= pcm_pkg::REG_RST;
      off_h_ff <= pcm_pkg::REG_RST;
      off_l_ff <= pcm_pkg::REG_RST;
      for (int i = 0; i < pcm_pkg::MIRROR_REGS; i++)
        mirror_ff[i] <= pcm_pkg::REG_RST;
      pos2_ff <= '0;
      sm_busy_ff <= 1'b0;
      lm_busy_ff <= 1'b0;
      sm_req_ff <= 1'b0;
      sm_write_ff <= 1'b0;
      sm_addr_ff <= '0;
      sm_wdata_ff <= '0;
      lm_req_ff <= 1'b0;
      lm_data_ff <= '0;
      rd1_ff <= 1'b0;
      rd1_addr_ff <= '0;
      s1_rdata_ff <= '0;
      s2_rdata_ff <= '0;
      s1_rvalid_ff <= 1'b0;
      s2_rvalid_ff <= 1'b0;
      online_ff <= 8'h01;
    end
    else
    begin
      ev_low_ff <= nxt_ev_low;
      ev_short_ff <= nxt_ev_short;
      mir_ans_ff <= nxt_mir_ans;
      rem_ans_ff <= nxt_rem_ans;
      addr_h_ff <= nxt_addr_h;
      addr_l_ff <= nxt_addr_l;
      off_h_ff <= nxt_off_h;
      off_l_ff <= nxt_off_l;
      mirror_ff <= nxt_mirror;
      pos2_ff <= nxt_pos2;
      sm_busy_ff <= nxt_sm_busy;
      lm_busy_ff <= nxt_lm_busy;
      sm_req_ff <= nxt_sm_req;
      sm_write_ff <= nxt_sm_write;
      sm_addr_ff <= nxt_sm_addr;
      sm_wdata_ff <= nxt_sm_wdata;
      lm_req_ff <= nxt_lm_req;
      lm_data_ff <= nxt_lm_data;
      rd1_ff <= nxt_rd1;
      rd1_addr_ff <= nxt_rd1_addr;
      s1_rdata_ff <= nxt_s1_rdata;
      s2_rdata_ff <= nxt_s2_rdata;
      s1_rvalid_ff <= nxt_s1_rvalid;
      s2_rvalid_ff <= nxt_s2_rvalid;
      online_ff <= nxt_online;
    end
  end

  assign s1_rdata = s1_rdata_ff;
  assign s1_rvalid = s1_rvalid_ff;
  assign s1_online_status = online_ff;
  assign s2_rdata = s2_rdata_ff;
  assign s2_rvalid = s2_rvalid_ff;
  assign sm_req = sm_req_ff;
  assign sm_write = sm_write_ff;
  assign sm_addr = sm_addr_ff;
  assign sm_wdata = sm_wdata_ff;
  assign lm_req = lm_req_ff;
  assign lm_addr_h = addr_h_ff;
  assign lm_addr_l = addr_l_ff;
  assign lm_off_h = off_h_ff;
  assign lm_off_l = off_l_ff;
  assign lm_data = lm_data_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_pos2_capture;
    link_pos2_valid |=> pos2_ff == $past(link_pos2);
  endproperty
  a_pos2_capture: assert property (p_pos2_capture) else $error("position not captured"); // see R01
  property p_s2_no_remote;
    (s2_rd && !s1_rd && !s1_wr) |=> !sm_req;
  endproperty
  a_s2_no_remote: assert property (p_s2_no_remote) else $error("second port started link"); // see R06
  property p_answer_lands;
    (sm_ans_valid && sm_busy_ff) |=> rem_ans_ff == $past(sm_ans_data) && ev_short_ff[0];
  endproperty
  a_answer_lands: assert property (p_answer_lands) else $error("short answer lost"); // see R07
  property p_short_msg_free_flag_low;
    sm_req |-> !ev_short_ff[pcm_pkg::SHORT_FREE_BIT] ##1 sm_busy_ff;
  endproperty
  a_short_msg_free_flag_low: assert property (p_short_msg_free_flag_low) else $error("short flag not cleared"); // see R09
  property p_online_bit;
    ##1 s1_online_status[0] == ev_short_ff[pcm_pkg::SHORT_FREE_BIT];
  endproperty
  a_online_bit: assert property (p_online_bit) else $error("online bit mismatch"); // see R10
  property p_mirror_now;
    (s1_rd && s1_addr == pcm_pkg::MIRROR_LO_OFF) |=> mir_ans_ff == $past(mirror_ff[0]);
  endproperty
  a_mirror_now: assert property (p_mirror_now) else $error("mirror answer late"); // see R11
  property p_one_short;
    sm_busy_ff && !sm_ans_valid |=> !sm_req;
  endproperty
  a_one_short: assert property (p_one_short) else $error("second short message issued"); // see R12
  property p_concurrent;
    (lm_busy_ff && s1_true_remote && !sm_busy_ff) |=> sm_req;
  endproperty
  a_concurrent: assert property (p_concurrent) else $error("short refused during long"); // see R13
  property p_fill;
    buf_fill |=> buf_flat == $past(lm_rd_data);
  endproperty
  a_fill: assert property (p_fill) else $error("long data not stored"); // see R15
  property p_long_msg_free_flag_set;
    (lm_done && lm_busy_ff) |=> ev_low_ff[pcm_pkg::LONG_FREE_BIT] && !lm_busy_ff;
  endproperty
  a_long_msg_free_flag_set: assert property (p_long_msg_free_flag_set) else $error("long flag not set"); // see R16
  property p_long_msg_free_flag_clear;
    (s1_wr && s1_addr == pcm_pkg::EVENT_LOW_OFF && s1_wdata[0] && !(lm_done && lm_busy_ff))
      |=> !ev_low_ff[pcm_pkg::LONG_FREE_BIT];
  endproperty
  a_long_msg_free_flag_clear: assert property (p_long_msg_free_flag_clear) else $error("host clear ignored"); // see R17

  c_short: cover property (sm_req ##[1:100] sm_ans_valid);
  c_long: cover property (lm_req ##[1:200] lm_done);
  c_both: cover property (sm_busy_ff && lm_busy_ff);
endmodule : pcm_ctrl

// >>> tb/pcm_enc_model.sv
// Behavioural encoder at the far end of the parameter channel
`timescale 1ns/1ps
module pcm_enc_model #(
  parameter logic [63:0] RD_PAT = 64'h0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Answer timing and error injection from the bench
  input wire logic [7:0] sm_lat,
  input wire logic [7:0] lm_lat,
  input wire logic err_en,
  // Short message link
  input wire logic sm_req,
  input wire logic sm_write,
  input wire logic [6:0] sm_addr,
  input wire logic [7:0] sm_wdata,
  output logic sm_ans_valid,
  output logic [7:0] sm_ans_data,
  // Long message link
  input wire logic lm_req,
  input wire logic [7:0] lm_addr_h,
  output logic lm_done,
  output logic lm_err,
  output logic [63:0] lm_rd_data
);
  logic sm_busy, lm_busy, lm_rd;
  logic [7:0] sm_cnt, lm_cnt;
  initial
  begin
    sm_ans_valid = 1'b0;
    sm_ans_data = 8'h00;
    lm_done = 1'b0;
    lm_err = 1'b0;
    lm_rd_data = 64'h0;
  end
  always @(posedge mclk)
  begin
    sm_ans_valid <= 1'b0;
    lm_done <= 1'b0;
    lm_err <= 1'b0;
    // Outside an answer the data lines toggle, so stale data never looks valid
    sm_ans_data <= ~sm_ans_data;
    lm_rd_data <= ~lm_rd_data;
    if (srst)
    begin
      sm_busy <= 1'b0;
      lm_busy <= 1'b0;
    end
    else
    begin
      if (sm_req)
      begin
        sm_busy <= 1'b1;
        sm_cnt <= sm_lat;
      end
      else if (sm_busy && sm_cnt != 8'h00)
        sm_cnt <= sm_cnt - 8'h01;
      else if (sm_busy)
      begin
        sm_busy <= 1'b0;
        sm_ans_valid <= 1'b1;
        sm_ans_data <= sm_write ? sm_wdata : ({1'b1, sm_addr} ^ 8'h5A);
      end
      if (lm_req)
      begin
        lm_busy <= 1'b1;
        lm_cnt <= lm_lat;
        lm_rd <= lm_addr_h[6];
      end
      else if (lm_busy && lm_cnt != 8'h00)
        lm_cnt <= lm_cnt - 8'h01;
      else if (lm_busy)
      begin
        lm_busy <= 1'b0;
        lm_done <= 1'b1;
        lm_err <= err_en;
        // A write answer carries junk that must not land in the buffer
        lm_rd_data <= lm_rd ? RD_PAT : ~RD_PAT;
      end
    end
  end
endmodule : pcm_enc_model

// >>> tb/parameter_channel_message_control_tb_top.sv
// Self-checking bench for the parameter channel message control block
`timescale 1ns/1ps
module parameter_channel_message_control_tb_top;
  localparam logic [63:0] RD_PAT = 64'hF1E2_D3C4_B5A6_9788;
  logic mclk, srst, s1_wr, s1_rd, s2_rd, link_pos2_valid, err_en;
  logic [6:0] s1_addr, s2_addr, sm_addr;
  logic [7:0] s1_wdata, s1_rdata, s1_online_status, s2_rdata, sm_lat, lm_lat, d;
  logic s1_rvalid, s2_rvalid, sm_req, sm_write, sm_ans_valid, lm_req, lm_done, lm_err;
  logic [39:0] link_pos2, pos;
  logic [7:0] sm_wdata, sm_ans_data, lm_addr_h, lm_addr_l, lm_off_h, lm_off_l;
  logic [63:0] lm_data, lm_rd_data, lm_seen;
  int mismatches = 0, check_count = 0, sm_reqs = 0, lm_reqs = 0;

  pcm_ctrl DUT (.mclk(mclk), .srst(srst), .s1_addr(s1_addr), .s1_wr(s1_wr), .s1_rd(s1_rd),
    .s1_wdata(s1_wdata), .s1_rdata(s1_rdata), .s1_rvalid(s1_rvalid),
    .s1_online_status(s1_online_status), .s2_addr(s2_addr), .s2_rd(s2_rd),
    .s2_rdata(s2_rdata), .s2_rvalid(s2_rvalid), .link_pos2_valid(link_pos2_valid),
    .link_pos2(link_pos2), .sm_req(sm_req), .sm_write(sm_write), .sm_addr(sm_addr),
    .sm_wdata(sm_wdata), .sm_ans_valid(sm_ans_valid), .sm_ans_data(sm_ans_data),
    .lm_req(lm_req), .lm_addr_h(lm_addr_h), .lm_addr_l(lm_addr_l), .lm_off_h(lm_off_h),
    .lm_off_l(lm_off_l), .lm_data(lm_data), .lm_done(lm_done), .lm_err(lm_err),
    .lm_rd_data(lm_rd_data));
  pcm_enc_model #(.RD_PAT(RD_PAT)) u_enc (.mclk(mclk), .srst(srst), .sm_lat(sm_lat),
    .lm_lat(lm_lat), .err_en(err_en), .sm_req(sm_req), .sm_write(sm_write),
    .sm_addr(sm_addr), .sm_wdata(sm_wdata), .sm_ans_valid(sm_ans_valid),
    .sm_ans_data(sm_ans_data), .lm_req(lm_req), .lm_addr_h(lm_addr_h),
    .lm_done(lm_done), .lm_err(lm_err), .lm_rd_data(lm_rd_data));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (sm_req === 1'b1) sm_reqs++;
    if (lm_req === 1'b1) lm_reqs++;
    if (lm_req === 1'b1) lm_seen <= lm_data;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic s1_read(input logic [6:0] a, output logic [7:0] q);
    @(posedge mclk);
    s1_rd <= 1'b1;
    s1_addr <= a;
    @(posedge mclk);
    s1_rd <= 1'b0;
    @(posedge mclk);
    #1;
    chk(s1_rvalid, 1'b1);
    q = s1_rdata;
  endtask : s1_read
  task automatic s1_write(input logic [6:0] a, input logic [7:0] v);
    @(posedge mclk);
    s1_wr <= 1'b1;
    s1_addr <= a;
    s1_wdata <= v;
    @(posedge mclk);
    s1_wr <= 1'b0;
  endtask : s1_write
  task automatic s2_read(input logic [6:0] a, output logic [7:0] q);
    @(posedge mclk);
    s2_rd <= 1'b1;
    s2_addr <= a;
    @(posedge mclk);
    s2_rd <= 1'b0;
    #1;
    chk(s2_rvalid, 1'b1);
    q = s2_rdata;
  endtask : s2_read
  task automatic wait_short();
    for (int i = 0; i < 200 && s1_online_status[0] !== 1'b1; i++) @(posedge mclk);
    #1;
    chk(s1_online_status[0], 1'b1);
  endtask : wait_short
  task automatic wait_long();
    logic [7:0] q;
    q = 8'h00;
    for (int i = 0; i < 60 && q[0] !== 1'b1; i++) s1_read(pcm_pkg::EVENT_LOW_OFF, q);
    chk(q[0], 1'b1);
  endtask : wait_long
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  function automatic logic [7:0] rval(input logic [6:0] a);
    return {1'b1, a} ^ 8'h5A;
  endfunction : rval

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("unexpected at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
    give_verdict();
  end
  initial
  begin
    {srst, s1_wr, s1_rd, s2_rd, link_pos2_valid, err_en} = 6'h20;
    {s1_addr, s2_addr, s1_wdata, link_pos2} = '0;
    sm_lat = 8'h14;
    lm_lat = 8'h1E;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    s1_read(pcm_pkg::EVENT_LOW_OFF, d);
    chk(d, pcm_pkg::EVENT_LOW_RST);
    s1_read(pcm_pkg::EVENT_SHORT_OFF, d);
    chk(d, 8'h01);
    chk(s1_online_status, 8'h01);
    $display("test reset done");
    s1_read(pcm_pkg::REMOTE_LO_OFF, d);
    chk({sm_reqs[7:0], sm_addr, s1_online_status[0]}, {8'h01, 7'h40, 1'b0});
    s1_read(pcm_pkg::EVENT_SHORT_OFF, d);
    chk(d[0], 1'b0);
    s1_read(7'h41, d);
    wait_short();
    chk(sm_reqs, 1);
    s1_read(pcm_pkg::REMOTE_ANS_OFF, d);
    chk(d, rval(7'h40));
    s2_read(pcm_pkg::MIRROR_LO_OFF, d);
    chk(d, rval(7'h40));
    s1_read(pcm_pkg::MIRROR_LO_OFF, d);
    chk(d, rval(7'h40));
    s1_read(pcm_pkg::MIRROR_ANS_OFF, d);
    chk(d, rval(7'h40));
    s2_read(7'h50, d);
    chk(sm_reqs, 1);
    sm_lat <= 8'h03;
    s1_write(7'h48, 8'h3C);
    repeat (2) @(posedge mclk);
    #1;
    chk({sm_write, sm_addr, sm_wdata}, {1'b1, 7'h48, 8'h3C});
    wait_short();
    s1_read(pcm_pkg::REMOTE_ANS_OFF, d);
    chk(d, 8'h3C);
    $display("test short message done");
    sm_lat <= 8'h14;
    for (int i = 0; i < 8; i++) s1_write(pcm_pkg::LONG_BUF_OFF + 7'(i), 8'h10 + 8'(i));
    s1_write(pcm_pkg::LONG_ADDR_H_OFF, 8'h03);
    s1_write(pcm_pkg::LONG_ADDR_L_OFF, 8'h11);
    s1_write(pcm_pkg::LONG_OFF_H_OFF, 8'h22);
    s1_write(pcm_pkg::LONG_OFF_L_OFF, 8'h33);
    s1_write(pcm_pkg::LONG_CTRL_OFF, 8'h01);
    s1_read(pcm_pkg::EVENT_LOW_OFF, d);
    chk(d[0], 1'b0);
    chk(lm_seen, 64'h1716_1514_1312_1110);
    chk({lm_addr_h, lm_addr_l, lm_off_h, lm_off_l}, 32'h0311_2233);
    s1_read(7'h42, d);
    chk(sm_reqs, 3);
    s1_write(pcm_pkg::LONG_ADDR_H_OFF, 8'h00);
    wait_short();
    wait_long();
    s1_read(pcm_pkg::LONG_ADDR_H_OFF, d);
    chk(d, 8'h03);
    s1_read(pcm_pkg::LONG_BUF_OFF, d);
    chk(d, 8'h10);
    err_en <= 1'b1;
    s1_read(7'h43, d);
    s1_write(pcm_pkg::LONG_ADDR_H_OFF, 8'h43);
    s1_write(pcm_pkg::LONG_CTRL_OFF, 8'h01);
    repeat (2) @(posedge mclk);
    #1;
    chk(lm_reqs, 2);
    wait_long();
    for (int i = 0; i < 8; i++)
    begin
      s1_read(pcm_pkg::LONG_BUF_OFF + 7'(i), d);
      chk(d, RD_PAT[8*i +: 8]);
    end
    s1_read(pcm_pkg::LONG_ADDR_H_OFF, d);
    chk(d, 8'h63);
    wait_short();
    $display("test long message done");
    s1_write(pcm_pkg::EVENT_LOW_OFF, 8'h01);
    s1_read(pcm_pkg::EVENT_LOW_OFF, d);
    chk(d[0], 1'b0);
    err_en <= 1'b0;
    s1_write(pcm_pkg::LONG_ADDR_H_OFF, 8'h00);
    s1_write(pcm_pkg::LONG_CTRL_OFF, 8'h01);
    wait_long();
    chk(lm_reqs, 3);
    $display("test host clear done");
    for (int k = 0; k < 2; k++)
    begin
      pos = (k == 0) ? 40'hA1_B2C3_D4E5 : 40'h0F_1E2D_3C4B;
      @(posedge mclk);
      link_pos2 <= pos;
      link_pos2_valid <= 1'b1;
      @(posedge mclk);
      link_pos2_valid <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
        s2_read(7'(i), d);
        chk(d, pos[8*i +: 8]);
      end
      chk(d[7:4], pos[39:36]);
    end
    $display("test secondary position done");
    give_verdict();
  end
endmodule : parameter_channel_message_control_tb_top
